/* hw/ebp_pattern_test.sv */
// How it works
// - one type bit selects pattern for both generator and checker.
// - type 0 gives x^15+x^14+1 sequence, type 1 quasi-random signal.
// - switch clear: pattern goes out toward the line.
// - switch set: pattern goes out on the receive backplane.
// - injected error goes to whichever output carries the pattern.
// - only a 0-to-1 inject write flips exactly one output bit.
// - inject does nothing while generation is off.
// - switch clear: invert line output and line-side checked input.
// - switch set: invert backplane output and backplane checked input.
// - invert 0 inverts nothing; invert 1 inverts output and checked input on the switch-selected side only.
// - generator enable at bit 2 turns generation on.
// - checker enable at bit 3 checks line or transmit backplane data.
// - read-only bit 4 shows checker lock.
//
// The register addresses and register access over Wishbone were decided locally.
module ebp_pattern_test #(
    parameter int unsigned BIT_DIV_P = ebp_pkg::BIT_DIV
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ebp_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic test_switch,
    input wire logic tx_framer_data,
    input wire logic rx_framer_data,
    input wire logic line_rx_data,
    input wire logic tx_bp_data,
    output logic line_tx_data,
    output logic rx_bp_data
);
    import ebp_pkg::*;

    localparam int unsigned MC_W = $clog2(LOCK_MATCH + 1);
    localparam int unsigned WC_W = $clog2(LOSS_WIN + 1);
    localparam int unsigned EC_W = $clog2(LOSS_ERRS + 1);

    if (BIT_DIV_P < 2 || BIT_DIV_P > 65535) begin : g_bad_div
        $error("BIT_DIV_P must lie in 2..65535");
    end

    function automatic logic hit(input logic [ADR_W-1:0] adr,
                                 input logic [7:0] off);
        hit = (adr == off);
    endfunction

    // bit-rate divider
    logic [15:0] div_ff, nxt_div;
    logic bit_en;

    always_comb begin
        bit_en = (div_ff == 16'(BIT_DIV_P - 1));
        nxt_div = bit_en ? 16'h0000 : div_ff + 16'h0001;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // pin synchronisers, stage 0 read only by stage 1
    logic [1:0] lrx_sync_ff, tbp_sync_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lrx_sync_ff <= 2'h0;
            tbp_sync_ff <= 2'h0;
        end else begin
            lrx_sync_ff <= {lrx_sync_ff[0], line_rx_data};
            tbp_sync_ff <= {tbp_sync_ff[0], tx_bp_data};
        end
    end

    // bus slave: read data latched with ack, write lands on ack edge
    logic req, wr_go, ack_ff, nxt_ack, inj_ff, nxt_inj, inj_edge, lock;
    logic [31:0] rd_ff, nxt_rd;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [EV_W-1:0] sts_ff, nxt_sts, msk_ff, nxt_msk, ev;
    logic [ERR_CNT_W-1:0] errc_ff, nxt_errc;

    always_comb begin
        req = wb_cyc_i & wb_stb_i;
        wr_go = req & ack_ff & wb_we_i & wb_sel_i[0];
        nxt_ack = req & ~ack_ff;
        nxt_rd = rd_ff;
        if (req && !ack_ff && !wb_we_i) begin
            nxt_rd = 32'h0000_0000;
            if (hit(wb_adr_i, REG_CTRL)) begin
                nxt_rd[7:0] = ctrl_ff;
                nxt_rd[CTL_LOCK] = lock;
            end else if (hit(wb_adr_i, REG_IRQ_STS)) begin
                nxt_rd[EV_W-1:0] = sts_ff;
            end else if (hit(wb_adr_i, REG_IRQ_MSK)) begin
                nxt_rd[EV_W-1:0] = msk_ff;
            end else if (hit(wb_adr_i, REG_ERR_CNT)) begin
                nxt_rd[ERR_CNT_W-1:0] = errc_ff;
            end
        end
        nxt_ctrl = ctrl_ff;
        nxt_msk = msk_ff;
        inj_edge = 1'b0;
        if (wr_go && hit(wb_adr_i, REG_CTRL)) begin
            nxt_ctrl = wb_dat_i[7:0] & CTL_RW_MASK;
            inj_edge = wb_dat_i[CTL_INJ] & ~ctrl_ff[CTL_INJ];
        end
        if (wr_go && hit(wb_adr_i, REG_IRQ_MSK)) begin
            nxt_msk = wb_dat_i[EV_W-1:0];
        end
        // a new event wins over a same-cycle clear
        nxt_sts = sts_ff | ev;
        if (wr_go && hit(wb_adr_i, REG_IRQ_STS)) begin
            nxt_sts = (sts_ff & ~wb_dat_i[EV_W-1:0]) | ev;
        end
        nxt_errc = errc_ff;
        if (wr_go && hit(wb_adr_i, REG_ERR_CNT)) begin
            nxt_errc = '0;
        end
        if (ev[EV_ERR] && errc_ff != '1) begin
            nxt_errc = errc_ff + 1'b1;
        end
        // pending flip waits for the next bit slot
        nxt_inj = inj_ff;
        if (!nxt_ctrl[CTL_GEN]) begin
            nxt_inj = 1'b0;
        end else if (inj_edge) begin
            nxt_inj = 1'b1;
        end else if (bit_en) begin
            nxt_inj = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
            ctrl_ff <= CTL_RST;
            sts_ff <= IRQ_RST;
            msk_ff <= IRQ_RST;
            errc_ff <= '0;
            inj_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
            rd_ff <= nxt_rd;
            ctrl_ff <= nxt_ctrl;
            sts_ff <= nxt_sts;
            msk_ff <= nxt_msk;
            errc_ff <= nxt_errc;
            inj_ff <= nxt_inj;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rd_ff;
    assign irq = |(sts_ff & msk_ff);

    // generator
    logic gen_en, chk_en, inv, pat_type, gen_bit, pat_out;
    logic line_tx_ff, nxt_ltx, rx_bp_ff, nxt_rbp;

    assign gen_en = ctrl_ff[CTL_GEN];
    assign chk_en = ctrl_ff[CTL_CHK];
    assign inv = ctrl_ff[CTL_INV];
    assign pat_type = ctrl_ff[CTL_TYPE];

    ebp_pattern_core u_gen (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(gen_en),
        .step(bit_en),
        .mode(pat_type),
        .load(1'b0),
        .load_bit(1'b0),
        .out_bit(gen_bit)
    );

    always_comb begin
        pat_out = gen_bit ^ inv ^ inj_ff;
        nxt_ltx = line_tx_ff;
        nxt_rbp = rx_bp_ff;
        if (bit_en) begin
            nxt_ltx = (gen_en && !test_switch) ? pat_out
                                               : tx_framer_data;
            nxt_rbp = (gen_en && test_switch) ? pat_out
                                              : rx_framer_data;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_tx_ff <= 1'b0;
            rx_bp_ff <= 1'b0;
        end else begin
            line_tx_ff <= nxt_ltx;
            rx_bp_ff <= nxt_rbp;
        end
    end

    assign line_tx_data = line_tx_ff;
    assign rx_bp_data = rx_bp_ff;

    // checker: hunts by loading received bits, then free-runs once locked
    ebp_chk_e chk_ff, nxt_chk;
    logic [MC_W-1:0] mcnt_ff, nxt_mcnt;
    logic [WC_W-1:0] wcnt_ff, nxt_wcnt;
    logic [EC_W-1:0] ecnt_ff, nxt_ecnt;
    logic chk_in, exp_bit, miss;

    always_comb begin
        chk_in = test_switch ? tbp_sync_ff[1]
                             : lrx_sync_ff[1];
        chk_in = chk_in ^ inv;
    end

    ebp_pattern_core u_chk (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(chk_en),
        .step(bit_en),
        .mode(pat_type),
        .load(chk_ff == CHK_HUNT),
        .load_bit(chk_in),
        .out_bit(exp_bit)
    );

    always_comb begin
        miss = chk_in ^ exp_bit;
        nxt_chk = chk_ff;
        nxt_mcnt = mcnt_ff;
        nxt_wcnt = wcnt_ff;
        nxt_ecnt = ecnt_ff;
        ev = '0;
        unique case (chk_ff)
            CHK_OFF: begin
                nxt_mcnt = '0;
                if (chk_en) begin
                    nxt_chk = CHK_HUNT;
                end
            end
            CHK_HUNT: begin
                if (!chk_en) begin
                    nxt_chk = CHK_OFF;
                end else if (bit_en && miss) begin
                    nxt_mcnt = '0;
                end else if (bit_en) begin
                    nxt_mcnt = mcnt_ff + 1'b1;
                    if (mcnt_ff == MC_W'(LOCK_MATCH - 1)) begin
                        nxt_chk = CHK_LOCKED;
                        nxt_wcnt = '0;
                        nxt_ecnt = '0;
                        ev[EV_LOCK] = 1'b1;
                    end
                end
            end
            CHK_LOCKED: begin
                if (!chk_en) begin
                    nxt_chk = CHK_OFF;
                end else if (bit_en) begin
                    nxt_wcnt = wcnt_ff + 1'b1;
                    if (miss) begin
                        nxt_ecnt = ecnt_ff + 1'b1;
                        ev[EV_ERR] = 1'b1;
                    end
                    if (miss && ecnt_ff == EC_W'(LOSS_ERRS - 1)) begin
                        // too many errors in one window: hunt again
                        nxt_chk = CHK_HUNT;
                        nxt_mcnt = '0;
                        ev[EV_LOSS] = 1'b1;
                    end else if (wcnt_ff == WC_W'(LOSS_WIN - 1)) begin
                        nxt_wcnt = '0;
                        nxt_ecnt = '0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chk_ff <= CHK_OFF;
            mcnt_ff <= '0;
            wcnt_ff <= '0;
            ecnt_ff <= '0;
        end else begin
            chk_ff <= nxt_chk;
            mcnt_ff <= nxt_mcnt;
            wcnt_ff <= nxt_wcnt;
            ecnt_ff <= nxt_ecnt;
        end
    end

    assign lock = (chk_ff == CHK_LOCKED);

    property p_line_pattern;
        @(posedge sys_clk) disable iff (sys_rst)
        bit_en && gen_en && !test_switch && !inj_ff
        |=> line_tx_data == ($past(gen_bit) ^ $past(inv));
    endproperty
    a_line_pattern: assert property (p_line_pattern)
        else $error("line output does not carry the pattern");
    property p_bp_pattern;
        @(posedge sys_clk) disable iff (sys_rst)
        bit_en && gen_en && test_switch && !inj_ff
        |=> rx_bp_data == ($past(gen_bit) ^ $past(inv));
    endproperty
    a_bp_pattern: assert property (p_bp_pattern)
        else $error("backplane output does not carry the pattern");
    property p_inject_flip;
        @(posedge sys_clk) disable iff (sys_rst)
        bit_en && inj_ff && gen_en && !test_switch
        |=> line_tx_data != ($past(gen_bit) ^ $past(inv)) && !inj_ff;
    endproperty
    a_inject_flip: assert property (p_inject_flip)
        else $error("injected error missing or repeated");
    property p_inject_edge;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(inj_ff) |-> $past(wr_go) && !$past(ctrl_ff[CTL_INJ])
            && ctrl_ff[CTL_INJ];
    endproperty
    a_inject_edge: assert property (p_inject_edge)
        else $error("error injected without a rising control");
    property p_inject_gen;
        @(posedge sys_clk) disable iff (sys_rst)
        inj_ff |-> gen_en;
    endproperty
    a_inject_gen: assert property (p_inject_gen)
        else $error("injection pending while generator off");
    property p_pass_through;
        @(posedge sys_clk) disable iff (sys_rst)
        bit_en && !gen_en |=> line_tx_data == $past(tx_framer_data)
            && rx_bp_data == $past(rx_framer_data);
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("output altered while generator off");
    property p_lock_off;
        @(posedge sys_clk) disable iff (sys_rst)
        !chk_en |=> !lock;
    endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("lock held with checker off");
    property p_lock_read;
        @(posedge sys_clk) disable iff (sys_rst)
        req && !ack_ff && !wb_we_i && hit(wb_adr_i, REG_CTRL)
        |=> wb_ack_o && wb_dat_o[CTL_LOCK] == $past(lock);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock bit not reported on read");
    property p_reset_clear;
        @(posedge sys_clk) $fell(sys_rst) |-> ctrl_ff == CTL_RST
            && !inj_ff && !lock;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("controls not cleared by reset");
    property p_invert;
        @(posedge sys_clk) disable iff (sys_rst)
        chk_in == ((test_switch ? $past(tx_bp_data, 2)
                                : $past(line_rx_data, 2)) ^ inv);
    endproperty
    a_invert: assert property (p_invert)
        else $error("checked input inversion wrong");
endmodule

/* hw/ebp_pkg.sv */
package ebp_pkg;
    localparam int unsigned SYS_CLK_HZ = 50_000_000;
    localparam int unsigned E1_BIT_HZ = 2_048_000;
    localparam int unsigned BIT_DIV = SYS_CLK_HZ / E1_BIT_HZ;

    localparam int unsigned ADR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_IRQ_STS = 8'h04;
    localparam logic [7:0] REG_IRQ_MSK = 8'h08;
    localparam logic [7:0] REG_ERR_CNT = 8'h0c;

    localparam int unsigned CTL_TYPE = 7;
    localparam int unsigned CTL_INJ = 6;
    localparam int unsigned CTL_INV = 5;
    localparam int unsigned CTL_LOCK = 4;
    localparam int unsigned CTL_CHK = 3;
    localparam int unsigned CTL_GEN = 2;
    localparam logic [7:0] CTL_RW_MASK = 8'hec;
    localparam logic [7:0] CTL_RST = 8'h00;

    localparam int unsigned EV_LOCK = 0;
    localparam int unsigned EV_LOSS = 1;
    localparam int unsigned EV_ERR = 2;
    localparam int unsigned EV_W = 3;
    localparam logic [EV_W-1:0] IRQ_RST = 3'h0;
    localparam int unsigned ERR_CNT_W = 16;

    localparam int unsigned LOCK_MATCH = 32;
    localparam int unsigned LOSS_WIN = 64;
    localparam int unsigned LOSS_ERRS = 6;

    localparam int unsigned LFSR_W = 20;
    localparam int unsigned PRBS15_TAP_A = 14;
    localparam int unsigned PRBS15_TAP_B = 13;
    localparam int unsigned QRTS_TAP_A = 19;
    localparam int unsigned QRTS_TAP_B = 16;
    localparam int unsigned QRTS_ZRUN = 14;
    localparam logic PAT_PRBS15 = 1'b0;
    localparam logic PAT_QRTS = 1'b1;

    typedef enum logic [1:0] {
        CHK_OFF,
        CHK_HUNT,
        CHK_LOCKED
    } ebp_chk_e;
endpackage

/* hw/ebp_pattern_core.sv */
module ebp_pattern_core (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic step,
    input wire logic mode,
    input wire logic load,
    input wire logic load_bit,
    output logic out_bit
);
    import ebp_pkg::*;

    logic [LFSR_W-1:0] st_ff;
    logic [LFSR_W-1:0] nxt_st;
    logic fb;
    logic stuck;

    always_comb begin
        if (mode == PAT_QRTS) begin
            fb = st_ff[QRTS_TAP_A] ^ st_ff[QRTS_TAP_B];
            stuck = (st_ff == '0);
        end else begin
            fb = st_ff[PRBS15_TAP_A] ^ st_ff[PRBS15_TAP_B];
            stuck = (st_ff[PRBS15_TAP_A:0] == '0);
        end
        // an all-zero register would never leave zero
        if (stuck) begin
            fb = 1'b1;
        end
        out_bit = fb;
        // quasi-random signal bounds runs of zeros
        if (mode == PAT_QRTS && st_ff[QRTS_ZRUN-1:0] == '0) begin
            out_bit = 1'b1;
        end
        nxt_st = st_ff;
        if (!run) begin
            nxt_st = '0;
        end else if (step) begin
            nxt_st = {st_ff[LFSR_W-2:0], load ? load_bit : fb};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

/* sim/ebp_line_model.sv */
module ebp_line_model (
    input wire logic sys_clk,
    input wire logic brk,
    input wire logic line_tx_data,
    input wire logic rx_bp_data,
    output logic line_rx_data,
    output logic tx_bp_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // test set loops the pattern straight back on both paths
    initial begin
        line_rx_data = 1'b0;
        tx_bp_data = 1'b0;
    end

    // brk holds the return at 1: all-ones never satisfies the pattern
    // recurrence, so the checker cannot relock on it
    always @(posedge sys_clk) begin
        line_rx_data <= brk ? 1'b1 : line_tx_data;
        tx_bp_data <= brk ? 1'b1 : rx_bp_data;
    end
endmodule

/* sim/test_ebp_pattern_test.sv */
module test_ebp_pattern_test;
    import ebp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned BD = 4;
    logic sys_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, irq, sw, brk;
    logic [ADR_W-1:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    logic line_tx, rx_bp, line_rx, tx_bp;
    logic [99:0] q;
    int errors, num_checks;

    ebp_pattern_test #(.BIT_DIV_P(BD)) dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .irq(irq), .test_switch(sw), .tx_framer_data(1'b1),
        .rx_framer_data(1'b0), .line_rx_data(line_rx), .tx_bp_data(tx_bp),
        .line_tx_data(line_tx), .rx_bp_data(rx_bp));

    ebp_line_model far (.sys_clk(sys_clk), .brk(brk), .line_tx_data(line_tx),
        .rx_bp_data(rx_bp), .line_rx_data(line_rx), .tx_bp_data(tx_bp));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // ack sampled at the edge; request released only after that edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        wb_sel <= 4'hf;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            check(32'h0, 32'h1, "bus ack timeout");
            close_out();
        end else begin
            r = wb_rdat;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
            wb_we <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        check(r, e, "register read");
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one sample per bit slot, taken mid-cycle where outputs are settled
    task automatic grab(input logic src);
        repeat (2 * BD) @(negedge sys_clk);
        for (int i = 0; i < 100; i++) begin
            repeat (BD) @(negedge sys_clk);
            q[i] = src ? rx_bp : line_tx;
        end
        @(posedge sys_clk);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        if (irq !== 1'b1) begin
            check(32'h0, 32'h1, "irq timeout");
            close_out();
        end else begin
            @(posedge sys_clk);
        end
    endtask

    // slots breaking b[n] = b[n-14] ^ b[n-15] (^1 when inverted)
    function automatic int viol(input logic inv);
        int c;
        c = 0;
        for (int i = 15; i < 100; i++)
            if (q[i] !== (q[i-14] ^ q[i-15] ^ inv))
                c++;
        return c;
    endfunction

    function automatic int max_zero();
        int run, mx;
        run = 0;
        mx = 0;
        for (int i = 0; i < 100; i++) begin
            run = (q[i] === 1'b0) ? run + 1 : 0;
            if (run > mx)
                mx = run;
        end
        return mx;
    endfunction

    task automatic t_reset();
        check(irq, 1'b0, "irq after reset");
        rd_chk(REG_CTRL, 32'h0);
        rd_chk(REG_IRQ_STS, 32'h0);
        rd_chk(REG_IRQ_MSK, 32'h0);
        rd_chk(REG_ERR_CNT, 32'h0);
        wr(8'h10, 32'hff);
        rd_chk(8'h10, 32'h0);
        wr(REG_CTRL, 32'hff);
        rd_chk(REG_CTRL, 32'hec);
        wr(REG_CTRL, 32'h0);
    endtask

    task automatic t_gen_off();
        sw <= 1'b0;
        wr(REG_CTRL, 32'h40);
        grab(1'b0);
        check(q === {100{1'b1}}, 1'b1, "inject while idle");
        wr(REG_CTRL, 32'h04);
        grab(1'b0);
        check(viol(1'b0), 0, "stale inject");
    endtask

    task automatic t_gen();
        logic s [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic [7:0] c [6] = '{8'h04, 8'h24, 8'h04, 8'h24, 8'h84, 8'h84};
        for (int k = 0; k < 6; k++) begin
            sw <= s[k];
            wr(REG_CTRL, {24'h0, c[k]});
            grab(s[k]);
            if (!c[k][7]) begin
                check(viol(c[k][5]), 0, "pattern law");
            end else begin
                check(max_zero() <= 14, 1'b1, "zero run");
                check(viol(1'b0) > 0, 1'b1, "type ignored");
            end
            grab(!s[k]);
            check(q === {100{s[k]}}, 1'b1, "idle path");
        end
    endtask

    task automatic t_inject(input logic s);
        sw <= s;
        wr(REG_CTRL, 32'h04);
        fork
            grab(s);
            begin
                wait_cyc(45 * BD);
                wr(REG_CTRL, 32'h44);
            end
        join
        check(viol(1'b0), 3, "single flip");
        grab(s);
        check(viol(1'b0), 0, "held inject");
    endtask

    task automatic t_lock(input logic s, input logic [7:0] c);
        sw <= s;
        brk <= 1'b0;
        wr(REG_IRQ_MSK, 32'h1);
        wr(REG_CTRL, {24'h0, c});
        wait_irq();
        rd_chk(REG_CTRL, {24'h0, c | 8'h10});
        rd_chk(REG_IRQ_STS, 32'h1);
        wr(REG_IRQ_STS, 32'h1);
        wait_cyc(2);
        check(irq, 1'b0, "irq after clear");
        wr(REG_CTRL, {24'h0, c | 8'h40});
        wait_cyc(20 * BD);
        rd_chk(REG_ERR_CNT, 32'h1);
        rd_chk(REG_IRQ_STS, 32'h4);
        check(irq, 1'b0, "masked irq");
        wr(REG_IRQ_MSK, 32'h2);
        brk <= 1'b1;
        wait_irq();
        rd_chk(REG_CTRL, {24'h0, c | 8'h40});
        rd_chk(REG_IRQ_STS, 32'h6);
        brk <= 1'b0;
        // generator kept running so the next lock starts from a dense state
        wr(REG_CTRL, 32'h04);
        wr(REG_IRQ_STS, 32'h7);
        wr(REG_ERR_CNT, 32'h0);
    endtask

    initial begin
        errors = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = '0;
        wb_sel = 4'h0;
        wb_wdat = 32'h0;
        sw = 1'b0;
        brk = 1'b0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_gen_off();
        t_gen();
        t_inject(1'b0);
        t_inject(1'b1);
        t_lock(1'b0, 8'h0c);
        t_lock(1'b1, 8'hac);
        close_out();
    end
endmodule
